// ==== src/mms_defines.svh ====
// register map, field positions, reset values and timing for the mgmt/stats/rx-control block
// Operation
// - writing the frame register starts a frame unless the divider is zero
// - divider going zero to non-zero sends the frame already held
// - rewriting the frame register mid-frame alters the rest of that frame
// - bits 29-28 pick write or read; bit 29 set means read
// - bits 27-23 address the PHY, bits 22-18 its register
// - bits 15-0 go out on write and receive PHY data on read
// - output holds hold-field plus one bus cycles after the MDC rising edge
// - preamble of 32 ones unless preamble_skip is set
// - MDC is bus clock over twice (divider plus one); zero holds it low
// - MDC at 50% duty; a change to a non-zero divider applies after the next MDC edge
// - stats_halt resets to one and freezes all statistics counters
// - stats_quiet reads one when idle; stats_zero clears all counters
// - length limit resets to 1518; longer frames raise overlength events
// - receive_halted reports a stopped rx path; bit 30 enables length check
// - control and pause frame filtering and pause honouring
// - pad stripping forces the CRC to be checked and stripped
// - RMII/MII select, bit 2 reads one, slow mode clock division
// - broadcast drop unless promiscuous; both set gives accept with miss
// - no receive while transmitting; loopback silences tx and uses bus clock
`ifndef MMS_DEFINES_SVH
`define MMS_DEFINES_SVH
`define MMS_OFS_EVENT 12'h004
`define MMS_OFS_FRAME 12'h040
`define MMS_OFS_CLKCTL 12'h044
`define MMS_OFS_STATS 12'h064
`define MMS_OFS_RXCTL 12'h084
`define MMS_EVT_DONE 23
`define MMS_CC_HOLD_LO 8
`define MMS_CC_SKIP 7
`define MMS_CC_DIV_LO 1
`define MMS_ST_HALT 31
`define MMS_ST_QUIET 30
`define MMS_ST_ZERO 29
`define MMS_RX_HALTED 31
`define MMS_RX_IF_MODE 2
`define MMS_RX_WMASK 32'h7fff_f33b
`define MMS_RX_RESET 32'h05ee_0004
`define MMS_LEN_RESET 14'h05ee
`define MMS_PRE_BITS 5'h1f
`define MMS_RD_RELEASE 5'h11
`define MMS_DATA_TOP 5'h0f
`define MMS_PAUSE_OPCODE 16'h0001
`define MMS_RESP_OKAY 2'h0
`define MMS_RESP_SLVERR 2'h2
`endif

// ==== src/mms_pkg.sv ====
// types shared by the mgmt/stats/rx-control block
package mms_pkg;
  typedef enum logic [2:0] {MMS_IDLE = 3'h1, MMS_PRE = 3'h2, MMS_FRM = 3'h4} mms_phase_e;
  typedef struct packed {
    logic valid;
    logic da_bcast;
    logic da_match;
    logic is_ctrl;
    logic [15:0] ctrl_opcode;
    logic [13:0] length;
  } mms_rx_hdr_s;
  typedef struct packed {
    logic valid;
    logic accept;
    logic miss;
    logic frame_too_long_flag;
  } mms_rx_verdict_s;
  typedef struct packed {
    logic length_field_check;
    logic [13:0] frame_length_limit;
    logic control_frame_filter;
    logic crc_strip;
    logic pause_frame_pass;
    logic pad_strip_enable;
    logic reduced_if_slow_mode;
    logic rmii_select;
    logic pause_honour_enable;
    logic broadcast_drop;
    logic accept_all_addresses;
    logic rx_block_during_tx;
    logic loopback;
    logic tx_mii_quiet;
    logic tx_line_clock_from_bus;
    logic [4:0] if_clk_div;
    logic [4:0] mac_clk_div;
  } mms_rx_cfg_s;
  typedef struct packed {
    logic awready;
    logic wready;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] frame;
    logic [2:0] hold;
    logic skip;
    logic [5:0] div;
    logic stats_halt;
    logic stats_zero;
    logic stats_quiet;
    logic [31:0] rxctl;
    logic evt_done;
    mms_phase_e phase;
    logic [4:0] bitcnt;
    logic [3:0] holdcnt;
    logic mdc;
    logic [5:0] divcnt;
    logic [5:0] curdiv;
    logic mdio_o;
    logic mdio_oe;
    logic mdio_s1;
    logic mdio_s2;
    logic halted_s1;
    logic halted_s2;
    mms_rx_cfg_s cfg;
    mms_rx_verdict_s verdict;
    logic tx_ovl;
  } mms_state_s;
endpackage : mms_pkg

// ==== src/mms_top.sv ====
// mgmt frame engine, statistics control and receive control behind AXI4-Lite
`include "mms_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module mms_top
  import mms_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [11:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [11:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic mdc_out,
  output logic mdio_out,
  output logic mdio_oe_out,
  input wire logic mdio_in,
  output logic mgmt_done_out,
  output logic stats_halt_out,
  output logic stats_zero_out,
  input wire logic stats_busy_in,
  input wire logic receive_halted_in,
  input wire logic tx_active_in,
  input wire mms_rx_hdr_s rx_hdr_in,
  input wire logic tx_len_valid_in,
  input wire logic [13:0] tx_len_in,
  output mms_rx_cfg_s rx_cfg_out,
  output mms_rx_verdict_s rx_verdict_out,
  output logic rx_overlength_event_out,
  output logic tx_overlength_event_out
);

  mms_state_s s;
  mms_state_s next_s;

  // byte-lane merge of a write into an existing word
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  // frame bit on the wire; frame bits are read live from the register
  function automatic logic frame_bit(input logic [31:0] fr, input logic [4:0] idx);
    return fr[idx];
  endfunction : frame_bit

  // read frames hand the line to the PHY from the turnaround on
  function automatic logic drive_bit(input logic [31:0] fr, input logic [4:0] idx);
    return !(fr[29] && idx <= `MMS_RD_RELEASE);
  endfunction : drive_bit

  function automatic logic [31:0] clkctl_word(input mms_state_s st);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`MMS_CC_HOLD_LO +: 3] = st.hold;
    w[`MMS_CC_SKIP] = st.skip;
    w[`MMS_CC_DIV_LO +: 6] = st.div;
    return w;
  endfunction : clkctl_word

  function automatic logic [31:0] stats_word(input mms_state_s st);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`MMS_ST_HALT] = st.stats_halt;
    w[`MMS_ST_QUIET] = st.stats_quiet;
    w[`MMS_ST_ZERO] = st.stats_zero;
    return w;
  endfunction : stats_word

  logic start;
  logic rise;
  logic advance;
  logic [31:0] merged;
  logic [31:0] rd_word;
  logic addr_ok;
  logic [31:0] wr_new;
  logic bcast_hit;
  logic addr_pass;
  logic ctrl_drop;
  logic pause_drop;
  logic too_long;

  always_comb
  begin
    next_s = s;
    start = 1'b0;
    rise = 1'b0;
    advance = 1'b0;
    merged = 32'h0000_0000;
    rd_word = 32'h0000_0000;
    addr_ok = 1'b1;
    wr_new = 32'h0000_0000;
    bcast_hit = 1'b0;
    addr_pass = 1'b0;
    ctrl_drop = 1'b0;
    pause_drop = 1'b0;
    too_long = 1'b0;

    // two-stage synchronisers for pin and foreign inputs
    next_s.mdio_s1 = mdio_in;
    next_s.mdio_s2 = s.mdio_s1;
    next_s.halted_s1 = receive_halted_in;
    next_s.halted_s2 = s.halted_s1;

    // write address and data are taken independently, in either order
    if (s.awready && s_axi_awvalid_in)
    begin
      next_s.awready = 1'b0;
      next_s.awaddr = s_axi_awaddr_in;
    end
    if (s.wready && s_axi_wvalid_in)
    begin
      next_s.wready = 1'b0;
      next_s.wdata = s_axi_wdata_in;
      next_s.wstrb = s_axi_wstrb_in;
    end
    if (s.bvalid && s_axi_bready_in)
    begin
      next_s.bvalid = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end

    if (!s.awready && !s.wready && !s.bvalid)
    begin
      next_s.bvalid = 1'b1;
      next_s.bresp = `MMS_RESP_OKAY;
      case ({s.awaddr[11:2], 2'h0})
        `MMS_OFS_EVENT:
        begin
          // write one to clear
          wr_new = s.wdata & {{8{s.wstrb[3]}}, {8{s.wstrb[2]}}, {8{s.wstrb[1]}}, {8{s.wstrb[0]}}};
          if (wr_new[`MMS_EVT_DONE])
          begin
            next_s.evt_done = 1'b0;
          end
        end
        `MMS_OFS_FRAME:
        begin
          next_s.frame = merge_bytes(s.frame, s.wdata, s.wstrb);
          start = (s.div != 6'h00);
        end
        `MMS_OFS_CLKCTL:
        begin
          merged = merge_bytes(clkctl_word(s), s.wdata, s.wstrb);
          next_s.hold = merged[`MMS_CC_HOLD_LO +: 3];
          next_s.skip = merged[`MMS_CC_SKIP];
          next_s.div = merged[`MMS_CC_DIV_LO +: 6];
          start = (s.div == 6'h00) && (next_s.div != 6'h00);
        end
        `MMS_OFS_STATS:
        begin
          merged = merge_bytes(stats_word(s), s.wdata, s.wstrb);
          next_s.stats_halt = merged[`MMS_ST_HALT];
          next_s.stats_zero = merged[`MMS_ST_ZERO];
        end
        `MMS_OFS_RXCTL:
        begin
          merged = merge_bytes(s.rxctl, s.wdata, s.wstrb);
          // bit 2 stays one, status and reserved bits stay clear
          next_s.rxctl = (merged & `MMS_RX_WMASK) | 32'h0000_0004;
        end
        default:
        begin
          next_s.bresp = `MMS_RESP_SLVERR;
        end
      endcase
    end

    // read channel: one read at a time, answered the cycle after acceptance
    case ({s_axi_araddr_in[11:2], 2'h0})
      `MMS_OFS_EVENT: rd_word = {8'h00, s.evt_done, 23'h000000};
      `MMS_OFS_FRAME: rd_word = s.frame;
      `MMS_OFS_CLKCTL: rd_word = clkctl_word(s);
      `MMS_OFS_STATS: rd_word = stats_word(s);
      `MMS_OFS_RXCTL: rd_word = {s.halted_s2, s.rxctl[30:0]};
      default: addr_ok = 1'b0;
    endcase
    if (s.arready && s_axi_arvalid_in)
    begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_word;
      next_s.rresp = addr_ok ? `MMS_RESP_OKAY : `MMS_RESP_SLVERR;
    end
    if (s.rvalid && s_axi_rready_in)
    begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end

    // MDC: half period of curdiv+1 cycles; new divider picked up at each edge
    if (s.div == 6'h00)
    begin
      next_s.mdc = 1'b0;
      next_s.divcnt = 6'h00;
      next_s.curdiv = 6'h00;
    end
    else if (s.curdiv == 6'h00)
    begin
      next_s.curdiv = s.div;
      next_s.divcnt = 6'h00;
    end
    else if (s.divcnt == s.curdiv)
    begin
      next_s.mdc = !s.mdc;
      next_s.divcnt = 6'h00;
      next_s.curdiv = s.div;
      rise = !s.mdc;
    end
    else
    begin
      next_s.divcnt = s.divcnt + 6'h01;
    end

    // frame engine
    case (s.phase)
      MMS_IDLE:
      begin
        if (start)
        begin
          // a start while busy is not possible when software waits for done
          next_s.bitcnt = `MMS_PRE_BITS;
          next_s.holdcnt = 4'h0;
          next_s.mdio_oe = 1'b1;
          if (next_s.skip)
          begin
            next_s.phase = MMS_FRM;
            next_s.mdio_o = frame_bit(next_s.frame, `MMS_PRE_BITS);
          end
          else
          begin
            next_s.phase = MMS_PRE;
            next_s.mdio_o = 1'b1;
          end
        end
      end
      MMS_PRE, MMS_FRM:
      begin
        if (rise && s.phase == MMS_FRM && s.frame[29] && s.bitcnt <= `MMS_DATA_TOP)
        begin
          next_s.frame[s.bitcnt] = s.mdio_s2;
        end
        // a hold longer than the mdc period delays the change instead of restarting it
        if (rise && s.holdcnt == 4'h0)
        begin
          next_s.holdcnt = {1'b0, s.hold} + 4'h1;
        end
        else if (s.holdcnt != 4'h0)
        begin
          next_s.holdcnt = s.holdcnt - 4'h1;
          advance = (s.holdcnt == 4'h1);
        end
        if (advance)
        begin
          if (s.bitcnt != 5'h00)
          begin
            next_s.bitcnt = s.bitcnt - 5'h01;
            if (s.phase == MMS_FRM)
            begin
              // fields go out msb first exactly as held
              next_s.mdio_o = frame_bit(s.frame, s.bitcnt - 5'h01);
              next_s.mdio_oe = drive_bit(s.frame, s.bitcnt - 5'h01);
            end
          end
          else if (s.phase == MMS_PRE)
          begin
            next_s.phase = MMS_FRM;
            next_s.bitcnt = `MMS_PRE_BITS;
            next_s.mdio_o = frame_bit(s.frame, `MMS_PRE_BITS);
            next_s.mdio_oe = 1'b1;
          end
          else
          begin
            next_s.phase = MMS_IDLE;
            next_s.mdio_o = 1'b0;
            next_s.mdio_oe = 1'b0;
          end
        end
      end
      default:
      begin
        next_s.phase = MMS_IDLE;
        next_s.mdio_oe = 1'b0;
      end
    endcase
    // done flag: completion wins over a same-cycle clear
    if (advance && s.phase == MMS_FRM && s.bitcnt == 5'h00)
    begin
      next_s.evt_done = 1'b1;
    end

    // statistics: idle when halted or the counters report no update
    next_s.stats_quiet = s.stats_halt || !stats_busy_in;

    // receive configuration seen by the datapath
    next_s.cfg.length_field_check = s.rxctl[30];
    next_s.cfg.frame_length_limit = s.rxctl[29:16];
    next_s.cfg.control_frame_filter = s.rxctl[15];
    next_s.cfg.crc_strip = s.rxctl[12] || s.rxctl[14];
    next_s.cfg.pause_frame_pass = s.rxctl[13];
    next_s.cfg.pad_strip_enable = s.rxctl[12];
    next_s.cfg.reduced_if_slow_mode = s.rxctl[9];
    next_s.cfg.rmii_select = s.rxctl[8];
    next_s.cfg.pause_honour_enable = s.rxctl[5];
    next_s.cfg.broadcast_drop = s.rxctl[4];
    next_s.cfg.accept_all_addresses = s.rxctl[3];
    next_s.cfg.rx_block_during_tx = s.rxctl[1];
    next_s.cfg.loopback = s.rxctl[0];
    next_s.cfg.tx_mii_quiet = s.rxctl[0];
    next_s.cfg.tx_line_clock_from_bus = s.rxctl[0];
    // rmii reference dividers; mii passes the line clocks through
    next_s.cfg.if_clk_div = (s.rxctl[8] && s.rxctl[9]) ? 5'h0a : 5'h01;
    next_s.cfg.mac_clk_div = !s.rxctl[8] ? 5'h01 : (s.rxctl[9] ? 5'h14 : 5'h02);

    // receive frame verdict, one cycle after the header strobe
    too_long = rx_hdr_in.length > s.rxctl[29:16];
    bcast_hit = rx_hdr_in.da_bcast;
    addr_pass = s.rxctl[3] || rx_hdr_in.da_match || (bcast_hit && !s.rxctl[4]);
    ctrl_drop = rx_hdr_in.is_ctrl && s.rxctl[15]
                && rx_hdr_in.ctrl_opcode != `MMS_PAUSE_OPCODE;
    pause_drop = rx_hdr_in.is_ctrl && !s.rxctl[13]
                 && rx_hdr_in.ctrl_opcode == `MMS_PAUSE_OPCODE;
    next_s.verdict.valid = rx_hdr_in.valid;
    next_s.verdict.accept = rx_hdr_in.valid && addr_pass && !ctrl_drop && !pause_drop
                            && !(s.rxctl[1] && tx_active_in);
    next_s.verdict.miss = rx_hdr_in.valid && bcast_hit && s.rxctl[4] && s.rxctl[3];
    next_s.verdict.frame_too_long_flag = rx_hdr_in.valid && too_long;
    next_s.tx_ovl = tx_len_valid_in && (tx_len_in > s.rxctl[29:16]);
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      s <= '0;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.stats_halt <= 1'b1;
      s.stats_quiet <= 1'b1;
      s.rxctl <= `MMS_RX_RESET;
      s.cfg.frame_length_limit <= `MMS_LEN_RESET;
      s.cfg.if_clk_div <= 5'h01;
      s.cfg.mac_clk_div <= 5'h01;
      s.phase <= MMS_IDLE;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign s_axi_awready_out = s.awready;
  assign s_axi_wready_out = s.wready;
  assign s_axi_bresp_out = s.bresp;
  assign s_axi_bvalid_out = s.bvalid;
  assign s_axi_arready_out = s.arready;
  assign s_axi_rdata_out = s.rdata;
  assign s_axi_rresp_out = s.rresp;
  assign s_axi_rvalid_out = s.rvalid;
  assign mdc_out = s.mdc;
  assign mdio_out = s.mdio_o;
  assign mdio_oe_out = s.mdio_oe;
  assign mgmt_done_out = s.evt_done;
  assign stats_halt_out = s.stats_halt;
  assign stats_zero_out = s.stats_zero;
  assign rx_cfg_out = s.cfg;
  assign rx_verdict_out = s.verdict;
  assign rx_overlength_event_out = s.verdict.frame_too_long_flag;
  assign tx_overlength_event_out = s.tx_ovl;

endmodule : mms_top
`default_nettype wire

// ==== tb/mms_phy_model.sv ====
// behavioural PHY on the management link: records frames, answers reads
`timescale 1ns/100ps
`default_nettype none
module mms_phy_model
(
  input wire logic clk_in,
  input wire logic mdc_in,
  input wire logic mdio_drv_in,
  input wire logic mdio_oe_in,
  input wire logic [15:0] rd_data_in,
  output logic mdio_line_out,
  output logic [63:0] bits_out,
  output logic [7:0] nbits_out
);
  logic mdc_q = 1'b0;
  logic oe_q = 1'b0;
  logic rd = 1'b0;
  logic drive = 1'b0;
  logic val = 1'b0;
  int falls = 0;
  initial
  begin
    bits_out = '0;
    nbits_out = '0;
  end
  // pull-up on the line: released reads high
  assign mdio_line_out = mdio_oe_in ? mdio_drv_in : (drive ? val : 1'b1);
  // sampled on the bus clock so every value is the one before the edge
  always @(posedge clk_in)
  begin
    mdc_q <= mdc_in;
    oe_q <= mdio_oe_in;
    // a bit first driven at the rise edge itself misses setup and is not a sample
    if (mdc_in && !mdc_q && mdio_oe_in && oe_q)
    begin
      bits_out <= {bits_out[62:0], mdio_drv_in};
      nbits_out <= (oe_q ? nbits_out : 8'd0) + 8'd1;
    end
    else if (mdio_oe_in && !oe_q)
      nbits_out <= 8'd0;
    if (!mdio_oe_in && oe_q)
    begin
      rd <= nbits_out == 8'd14 || nbits_out == 8'd46;
      falls <= 0;
    end
    else if (rd && !mdc_in && mdc_q)
    begin
      // low turnaround bit, then data msb first, moved after each fall
      falls <= falls + 1;
      drive <= falls >= 1 && falls <= 17;
      val <= (falls >= 2 && falls <= 17) ? rd_data_in[17 - falls] : 1'b0;
      if (falls >= 18)
        rd <= 1'b0;
    end
  end
endmodule : mms_phy_model
`default_nettype wire

// ==== tb/mms_top_asserts.sv ====
// port assertions for the mgmt/stats/rx-control block
`timescale 1ns/100ps
`default_nettype none
module mms_top_asserts
  import mms_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic mdc_out,
  input wire logic mdio_out,
  input wire logic mdio_oe_out,
  input wire logic mgmt_done_out,
  input wire logic stats_halt_out,
  input wire logic tx_active_in,
  input wire mms_rx_hdr_s rx_hdr_in,
  input wire logic tx_len_valid_in,
  input wire logic [13:0] tx_len_in,
  input wire mms_rx_cfg_s rx_cfg_out,
  input wire mms_rx_verdict_s rx_verdict_out,
  input wire logic rx_overlength_event_out,
  input wire logic tx_overlength_event_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  verdict_timing_a:
    assert property (rx_verdict_out.valid == $past(rx_hdr_in.valid)) else $error("verdict late");
  bcast_reject_a:
    assert property (rx_hdr_in.valid && rx_hdr_in.da_bcast && !rx_hdr_in.da_match
      && rx_cfg_out.broadcast_drop && !rx_cfg_out.accept_all_addresses |=> !rx_verdict_out.accept)
      else $error("broadcast accepted");
  rx_during_tx_a:
    assert property (rx_hdr_in.valid && tx_active_in && rx_cfg_out.rx_block_during_tx
      |=> !rx_verdict_out.accept) else $error("frame taken while sending");
  crc_forced_a:
    assert property (rx_cfg_out.pad_strip_enable |-> rx_cfg_out.crc_strip) else $error("crc kept");
  rx_long_a:
    assert property (rx_verdict_out.valid |-> rx_overlength_event_out ==
      ($past(rx_hdr_in.length) > $past(rx_cfg_out.frame_length_limit))) else $error("rx length");
  tx_long_a:
    assert property (tx_overlength_event_out == ($past(tx_len_valid_in)
      && $past(tx_len_in) > $past(rx_cfg_out.frame_length_limit))) else $error("tx length");
  reset_values_a:
    assert property ($fell(sys_rst_in) |-> stats_halt_out
      && rx_cfg_out.frame_length_limit == 14'h05ee) else $error("reset value");
  mdio_hold_a:
    assert property ($rose(mdc_out) && $past(mdio_oe_out) |-> $stable(mdio_out))
      else $error("mdio moved at mdc rise");
  done_release_a:
    assert property ($rose(mgmt_done_out) |-> !mdio_oe_out) else $error("done while driving");
endmodule : mms_top_asserts
`default_nettype wire

// ==== tb/test_mms_top.sv ====
// self-checking bench for the mgmt/stats/rx-control block
`timescale 1ns/100ps
`default_nettype none
module test_mms_top
  import mms_pkg::*;
;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [11:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
  logic [3:0] s_axi_wstrb_in;
  logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out;
  logic s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
  logic s_axi_rvalid_out, s_axi_rready_in, mdc_out, mdio_out, mdio_oe_out, mdio_in;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic mgmt_done_out, stats_halt_out, stats_zero_out, stats_busy_in, receive_halted_in;
  logic tx_active_in, tx_len_valid_in, rx_overlength_event_out, tx_overlength_event_out;
  logic [13:0] tx_len_in;
  logic [15:0] rd_data;
  logic [63:0] phy_bits;
  logic [7:0] phy_n;
  mms_rx_hdr_s rx_hdr_in;
  mms_rx_cfg_s rx_cfg_out;
  mms_rx_verdict_s rx_verdict_out;
  int mismatches = 0;
  int checks_done = 0;
  mms_top DUT (.*);
  mms_phy_model phy (.clk_in, .mdc_in(mdc_out), .mdio_drv_in(mdio_out), .mdio_oe_in(mdio_oe_out),
    .rd_data_in(rd_data), .mdio_line_out(mdio_in), .bits_out(phy_bits), .nbits_out(phy_n));
  always #5 clk_in = ~clk_in;
  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    if (mismatches == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] r;
    int n;
    n = 0;
    b = 1'b0;
    @(posedge clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    while (b !== 1'b1 && n < 100)
    begin
      @(negedge clk_in);
      aw = s_axi_awvalid_in & s_axi_awready_out;
      w = s_axi_wvalid_in & s_axi_wready_out;
      b = s_axi_bvalid_out;
      r = s_axi_bresp_out;
      @(posedge clk_in);
      if (aw)
        s_axi_awvalid_in <= 1'b0;
      if (w)
        s_axi_wvalid_in <= 1'b0;
      n++;
    end
    s_axi_bready_in <= 1'b0;
    check({b, r}, {1'b1, er});
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ar, v;
    logic [33:0] got;
    int n;
    n = 0;
    v = 1'b0;
    @(posedge clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    while (v !== 1'b1 && n < 100)
    begin
      @(negedge clk_in);
      ar = s_axi_arvalid_in & s_axi_arready_out;
      v = s_axi_rvalid_out;
      got = {s_axi_rresp_out, s_axi_rdata_out};
      @(posedge clk_in);
      if (ar)
        s_axi_arvalid_in <= 1'b0;
      n++;
    end
    s_axi_rready_in <= 1'b0;
    check({v, got}, {1'b1, er, e});
  endtask : rd
  task automatic wait_done();
    int n;
    n = 0;
    while (mgmt_done_out !== 1'b1 && n < 4000)
    begin
      @(negedge clk_in);
      n++;
    end
    check(mgmt_done_out, 1'b1);
    wr(12'h004, 32'h0080_0000, 2'h0);
    @(negedge clk_in);
    check(mgmt_done_out, 1'b0);
  endtask : wait_done
  initial
  begin
    #400000;
    mismatches++;
    results();
  end
  initial
  begin
    logic [31:0] v, f;
    logic [13:0] len;
    logic b, m, c, t, acc;
    logic [15:0] op;
    logic [4:0] md;
    logic [37:0] cx;
    int i, hi, per;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = '0;
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = '0;
    s_axi_wstrb_in = 4'hf;
    {receive_halted_in, tx_active_in, tx_len_valid_in, tx_len_in, rx_hdr_in} = '0;
    stats_busy_in = 1'b1;
    rd_data = 16'h0;
    v = $urandom(32'ha876a4f6);
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rd(12'h064, 32'hc000_0000, 2'h0);
    rd(12'h084, 32'h05ee_0004, 2'h0);
    rd(12'h0f0, 32'h0, 2'h2);
    wr(12'h0f0, 32'hffff_ffff, 2'h2);
    wr(12'h064, 32'h2000_0000, 2'h0);
    rd(12'h064, 32'h2000_0000, 2'h0);
    check({stats_halt_out, stats_zero_out}, 2'b01);
    stats_busy_in <= 1'b0;
    rd(12'h064, 32'h6000_0000, 2'h0);
    receive_halted_in <= 1'b1;
    for (i = 0; i < 4; i++)
    begin
      v = $urandom();
      v[9:8] = i[1:0];
      md = (i == 1) ? 5'd2 : ((i == 3) ? 5'd20 : 5'd1);
      wr(12'h084, v, 2'h0);
      rd(12'h084, (v & 32'h7fff_f33b) | 32'h8000_0004, 2'h0);
      check({rx_cfg_out.mac_clk_div, rx_cfg_out.if_clk_div}, {md, 5'(i == 3 ? 10 : 1)});
      check(rx_cfg_out.crc_strip, v[14] | v[12]);
      check({rx_cfg_out.tx_mii_quiet, rx_cfg_out.frame_length_limit}, {v[0], v[29:16]});
      cx = {v[30:15], v[14] | v[12], v[13:12], v[9:8], v[5:3], v[1], {3{v[0]}},
        5'(i == 3 ? 10 : 1), md};
      check(rx_cfg_out, cx);
    end
    for (i = 0; i < 40; i++)
    begin
      v = ($urandom() & 32'h0003_f03b) | 32'h0040_0000;
      {b, m, c, t} = 4'($urandom());
      m = m & !b;
      op = $urandom_range(0, 1) ? 16'h0001 : 16'($urandom());
      len = v[29:16] - 14'd1 + 14'($urandom_range(0, 2));
      acc = (v[3] | m | (b & !v[4])) & !(c & v[15] & op != 16'h0001)
        & !(c & op == 16'h0001 & !v[13]) & !(v[1] & t);
      wr(12'h084, v, 2'h0);
      rx_hdr_in <= {1'b1, b, m, c, op, len};
      tx_len_valid_in <= 1'b1;
      tx_len_in <= len;
      tx_active_in <= t;
      @(posedge clk_in);
      rx_hdr_in.valid <= 1'b0;
      tx_len_valid_in <= 1'b0;
      @(negedge clk_in);
      f = {acc, b & v[4] & v[3], {3{len > v[29:16]}}};
      check({rx_verdict_out, rx_overlength_event_out, tx_overlength_event_out}, {1'b1, f[4:0]});
    end
    // zero divider parks the frame until the divider turns non-zero
    wr(12'h044, 32'h0, 2'h0);
    f = {4'b0101, 5'($urandom()), 5'($urandom()), 2'b10, 16'($urandom())};
    wr(12'h040, f, 2'h0);
    hi = 0;
    repeat (40)
    begin
      @(negedge clk_in);
      if (mdio_oe_out !== 1'b0 || mdc_out !== 1'b0)
        hi++;
    end
    check(hi, 0);
    wr(12'h044, 32'h0000_00a6, 2'h0);
    wait_done();
    check({phy_n, phy_bits[31:0]}, {8'd32, f});
    f[29:28] = 2'b00;
    f[15:0] = 16'($urandom());
    wr(12'h044, 32'h0000_0728, 2'h0);
    wr(12'h040, f, 2'h0);
    {hi, per} = '0;
    while (mdc_out) @(negedge clk_in);
    while (!mdc_out) @(negedge clk_in);
    for (; mdc_out; hi++) @(negedge clk_in);
    for (; !mdc_out; per++) @(negedge clk_in);
    check({hi, per}, {32'd21, 32'd21});
    wait_done();
    check({phy_n, phy_bits}, {8'd64, 32'hffff_ffff, f});
    for (i = 2; i < 4; i++)
    begin
      rd_data = 16'($urandom());
      f = {2'b01, i[1:0], 5'($urandom()), 5'($urandom()), 2'b10, 16'h0};
      wr(12'h044, 32'h0000_01b0, 2'h0);
      wr(12'h040, f, 2'h0);
      wait_done();
      check(phy_n, 8'd14);
      rd(12'h040, {f[31:16], rd_data}, 2'h0);
    end
    results();
  end
endmodule : test_mms_top
bind mms_top mms_top_asserts chk (.clk_in, .sys_rst_in, .mdc_out, .mdio_out, .mdio_oe_out,
  .mgmt_done_out, .stats_halt_out, .tx_active_in, .rx_hdr_in, .tx_len_valid_in, .tx_len_in,
  .rx_cfg_out, .rx_verdict_out, .rx_overlength_event_out, .tx_overlength_event_out);
`default_nettype wire
